// >>> pwm_time_base_map.svh
// Register offsets, field positions, reset values and counts of the PWM time base.
// Assumes a 4-bit word address and 16-bit register data.
`ifndef PWM_TIME_BASE_MAP_SVH
`define PWM_TIME_BASE_MAP_SVH

`define TB_ADDR_W        4
`define TB_DATA_W        16
`define TB_CNT_W         15

`define TB_OFF_CONTROL   4'h0
`define TB_OFF_PERIOD    4'h1
`define TB_OFF_COUNTER   4'h2
`define TB_OFF_STATUS    4'h3

`define TB_CTL_RUN       15
`define TB_CTL_POST_LSB  8
`define TB_CTL_PRE_LSB   4
`define TB_CTL_MODE_LSB  0

`define TB_CNT_DIR       15

`define TB_STS_MATCH     0
`define TB_STS_REFUSED   1
`define TB_STS_DIR       2
`define TB_STS_RUN       3
`define TB_STS_POST_LSB  4

`define TB_RST_CONTROL   16'h0000
`define TB_RST_PERIOD    15'h0000
`define TB_RST_COUNTER   15'h0000

`define TB_PRE_DIV1      7'h01
`define TB_PRE_DIV4      7'h04
`define TB_PRE_DIV16     7'h10
`define TB_PRE_DIV64     7'h40

`endif

// >>> pwm_time_base_pkg.sv
// Types shared by the PWM time base and its prescaler.
// Assumes the map header is on the include path.
`include "pwm_time_base_map.svh"

package pwm_time_base_pkg;

    typedef enum logic [1:0] {
        MODE_FREE_RUN,
        MODE_SINGLE_SHOT,
        MODE_UP_DOWN,
        MODE_UP_DOWN_DBL
    } tb_mode_t;

    typedef struct packed {
        logic                  run;
        tb_mode_t              mode;
        logic [3:0]            post_sel;
        logic [1:0]            pre_sel;
        logic [`TB_CNT_W-1:0]  period;
        logic [`TB_CNT_W-1:0]  count;
        logic                  dir;
        logic [3:0]            post_cnt;
        logic                  match_seen;
        logic                  refused;
        logic                  event_out;
        logic                  match_out;
        logic [`TB_DATA_W-1:0] rd_data;
    } tb_state_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic       tick;
    } pre_state_t;

endpackage

// >>> pwm_prescale.sv
// Input-clock prescaler of the PWM time base: one-cycle tick every 1, 4, 16 or 64 clocks.
// Assumes run and sel come from logic on clk_sys.
`timescale 1ns/1ps
`include "pwm_time_base_map.svh"

module pwm_prescale #(
    parameter logic [6:0] DIV1  = `TB_PRE_DIV1,
    parameter logic [6:0] DIV4  = `TB_PRE_DIV4,
    parameter logic [6:0] DIV16 = `TB_PRE_DIV16,
    parameter logic [6:0] DIV64 = `TB_PRE_DIV64
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] sel,
    // Count enable
    output logic            tick
);

    pwm_time_base_pkg::pre_state_t st_ff;
    pwm_time_base_pkg::pre_state_t nxt_st;
    logic [6:0]                    ratio;

    always_comb begin
        case (sel)
            2'h0:    ratio = DIV1;
            2'h1:    ratio = DIV4;
            2'h2:    ratio = DIV16;
            default: ratio = DIV64;
        endcase
    end

    // The divider restarts from zero whenever the time base stops, so the
    // first count after enabling always takes a whole prescaled period.
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (!run) begin
            nxt_st.cnt = 7'h00;
        end else if (st_ff.cnt + 7'h01 >= ratio) begin
            nxt_st.cnt  = 7'h00;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 7'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

endmodule

// >>> pwm_time_base.sv
// PWM time base: 15-bit up or up/down counter with period, mode, prescaler and postscaler.
// Assumes a register master on clk_sys that keeps to the plain strobe port protocol.
//
// Function
// - 15-bit counter clocked via selectable prescaler, events via selectable postscaler.
// - Counter register bit 15 reads count direction: 0 up, 1 down; read-only.
// - Counter runs only while enabled; disabling leaves its value unchanged.
// - On count equal to period, reset to zero or reverse, per mode.
// - Period zero stops counting and suppresses every event.
// - Writes to a zero period are ignored while running; software disables first.
// - Two-bit mode: free-run, single-shot, up/down, up/down with double events.
// - Events depend on the mode field and the four-bit postscaler field.
// - Free-run counts up, clears after period match, repeats while enabled.
// - Free-run raises an event per match and reset, divided by postscaler.
// - Single-shot counts up, clears on match and clears the enable itself.
// - Single-shot raises one event at match, postscaler not applied.
// - Up/down modes reverse at period match and set direction while counting down.
// - Mode 10 raises an event at zero turnaround, divided by postscaler.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "pwm_time_base_map.svh"

module pwm_time_base #(
    parameter int CNT_W  = `TB_CNT_W,
    parameter int DATA_W = `TB_DATA_W,
    parameter int ADDR_W = `TB_ADDR_W
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Time base outputs for comparators and event logic
    output logic      [CNT_W-1:0]  count_value,
    output logic                   count_down_flag,
    output logic                   time_base_run,
    output logic                   period_match,
    output logic                   time_base_event
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    pwm_time_base_pkg::tb_state_t st_ff;
    pwm_time_base_pkg::tb_state_t nxt_st;
    logic                         tick;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the read and write paths.

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] off);
        addr_hit = (addr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler

    pwm_prescale u_prescale (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (st_ff.run),
        .sel     (st_ff.pre_sel),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic                at_period;
        logic                at_zero;
        logic                advance;
        logic                raw_event;
        logic                direct_event;
        logic                match_now;
        logic                wr_ctl;
        logic                wr_per;
        logic                wr_cnt;
        logic                wr_sts;
        logic [DATA_W-1:0]   rd_word;

        at_period    = 1'b0;
        at_zero      = 1'b0;
        advance      = 1'b0;
        raw_event    = 1'b0;
        direct_event = 1'b0;
        match_now    = 1'b0;
        wr_ctl       = 1'b0;
        wr_per       = 1'b0;
        wr_cnt       = 1'b0;
        wr_sts       = 1'b0;
        rd_word      = '0;

        nxt_st           = st_ff;
        nxt_st.event_out = 1'b0;
        nxt_st.match_out = 1'b0;
        nxt_st.rd_data   = '0;

        at_period = (st_ff.count == st_ff.period);
        at_zero   = (st_ff.count == '0);

        // A zero period freezes the counter and blocks every event source.
        advance = st_ff.run && tick && (st_ff.period != '0);

        //////////////////////////////////////////////////////////////////////////
        // Counting

        if (advance) begin
            case (st_ff.mode)
                pwm_time_base_pkg::MODE_FREE_RUN: begin
                    if (at_period) begin
                        nxt_st.count = '0;
                        match_now    = 1'b1;
                        raw_event    = 1'b1;
                    end else begin
                        nxt_st.count = st_ff.count + 1'b1;
                    end
                end
                pwm_time_base_pkg::MODE_SINGLE_SHOT: begin
                    if (at_period) begin
                        nxt_st.count = '0;
                        nxt_st.run   = 1'b0;
                        match_now    = 1'b1;
                        direct_event = 1'b1;
                    end else begin
                        nxt_st.count = st_ff.count + 1'b1;
                    end
                end
                pwm_time_base_pkg::MODE_UP_DOWN,
                pwm_time_base_pkg::MODE_UP_DOWN_DBL: begin
                    if (!st_ff.dir) begin
                        if (at_period) begin
                            nxt_st.dir   = 1'b1;
                            nxt_st.count = st_ff.count - 1'b1;
                            match_now    = 1'b1;
                            if (st_ff.mode == pwm_time_base_pkg::MODE_UP_DOWN_DBL) begin
                                raw_event = 1'b1;
                            end
                        end else begin
                            nxt_st.count = st_ff.count + 1'b1;
                        end
                    end else begin
                        if (at_zero) begin
                            nxt_st.dir   = 1'b0;
                            nxt_st.count = st_ff.count + 1'b1;
                            raw_event    = 1'b1;
                        end else begin
                            nxt_st.count = st_ff.count - 1'b1;
                        end
                    end
                end
                default: begin
                    nxt_st.count = st_ff.count;
                end
            endcase
        end

        //////////////////////////////////////////////////////////////////////////
        // Postscaler: passes one of every post_sel+1 events.

        if (raw_event) begin
            if (st_ff.post_cnt == st_ff.post_sel) begin
                nxt_st.post_cnt  = 4'h0;
                nxt_st.event_out = 1'b1;
            end else begin
                nxt_st.post_cnt = st_ff.post_cnt + 4'h1;
            end
        end
        if (direct_event) begin
            nxt_st.event_out = 1'b1;
        end
        nxt_st.match_out = match_now;

        //////////////////////////////////////////////////////////////////////////
        // Register writes. Software writes come after the counting logic so a
        // write in the same cycle as a hardware update is what software sees.

        if (reg_wr) begin
            if (addr_hit(reg_addr, `TB_OFF_CONTROL)) begin
                wr_ctl = 1'b1;
            end else if (addr_hit(reg_addr, `TB_OFF_PERIOD)) begin
                wr_per = 1'b1;
            end else if (addr_hit(reg_addr, `TB_OFF_COUNTER)) begin
                wr_cnt = 1'b1;
            end else if (addr_hit(reg_addr, `TB_OFF_STATUS)) begin
                wr_sts = 1'b1;
            end
        end

        if (wr_ctl) begin
            nxt_st.run      = reg_wdata[`TB_CTL_RUN];
            nxt_st.mode     = pwm_time_base_pkg::tb_mode_t'(reg_wdata[`TB_CTL_MODE_LSB +: 2]);
            nxt_st.post_sel = reg_wdata[`TB_CTL_POST_LSB +: 4];
            nxt_st.pre_sel  = reg_wdata[`TB_CTL_PRE_LSB +: 2];
            // Leaving the up/down modes must not leave a stale down direction.
            if (reg_wdata[`TB_CTL_MODE_LSB + 1] == 1'b0) begin
                nxt_st.dir = 1'b0;
            end
        end

        if (wr_per) begin
            // A zero period cannot be reloaded while the time base runs.
            if ((st_ff.period == '0) && st_ff.run) begin
                nxt_st.refused = 1'b1;
            end else begin
                nxt_st.period = reg_wdata[CNT_W-1:0];
            end
        end

        if (wr_cnt) begin
            // The direction bit is status only; writes to it are dropped.
            nxt_st.count = reg_wdata[CNT_W-1:0];
        end

        //////////////////////////////////////////////////////////////////////////
        // Sticky status bits, cleared by writing one. A new event in the same
        // cycle as its clear wins, so no match or refusal is ever lost.

        if (wr_sts && reg_wdata[`TB_STS_MATCH]) begin
            nxt_st.match_seen = 1'b0;
        end
        if (match_now) begin
            nxt_st.match_seen = 1'b1;
        end
        if (wr_sts && reg_wdata[`TB_STS_REFUSED] && !(wr_per && (st_ff.period == '0) && st_ff.run)) begin
            nxt_st.refused = 1'b0;
        end

        //////////////////////////////////////////////////////////////////////////
        // Register reads: data stand in the cycle after the strobe only.

        if (reg_rd) begin
            if (addr_hit(reg_addr, `TB_OFF_CONTROL)) begin
                rd_word[`TB_CTL_RUN]             = st_ff.run;
                rd_word[`TB_CTL_POST_LSB +: 4]   = st_ff.post_sel;
                rd_word[`TB_CTL_PRE_LSB +: 2]    = st_ff.pre_sel;
                rd_word[`TB_CTL_MODE_LSB +: 2]   = st_ff.mode;
            end else if (addr_hit(reg_addr, `TB_OFF_PERIOD)) begin
                rd_word[CNT_W-1:0] = st_ff.period;
            end else if (addr_hit(reg_addr, `TB_OFF_COUNTER)) begin
                rd_word[CNT_W-1:0]    = st_ff.count;
                rd_word[`TB_CNT_DIR]  = st_ff.dir;
            end else if (addr_hit(reg_addr, `TB_OFF_STATUS)) begin
                rd_word[`TB_STS_MATCH]        = st_ff.match_seen;
                rd_word[`TB_STS_REFUSED]      = st_ff.refused;
                rd_word[`TB_STS_DIR]          = st_ff.dir;
                rd_word[`TB_STS_RUN]          = st_ff.run;
                rd_word[`TB_STS_POST_LSB +: 4] = st_ff.post_cnt;
            end else begin
                rd_word = '0;
            end
        end
        nxt_st.rd_data = rd_word;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_ff          <= '0;
            st_ff.run      <= 1'(`TB_RST_CONTROL >> `TB_CTL_RUN);
            st_ff.period   <= `TB_RST_PERIOD;
            st_ff.count    <= `TB_RST_COUNTER;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata       = st_ff.rd_data;
    assign count_value     = st_ff.count;
    assign count_down_flag = st_ff.dir;
    assign time_base_run   = st_ff.run;
    assign period_match    = st_ff.match_out;
    assign time_base_event = st_ff.event_out;

endmodule

// >>> pwm_time_base_assertions.sv
// Port-level checks of the PWM time base counter, direction flag and event pulses.
// Assumes it is bound to pwm_time_base and sees only that module's ports.
`timescale 1ns/1ps
`include "pwm_time_base_map.svh"

module pwm_time_base_chk #(
    parameter int CNT_W  = 15,
    parameter int DATA_W = 16,
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Time base outputs
    input wire logic [CNT_W-1:0]  count_value,
    input wire logic              count_down_flag,
    input wire logic              time_base_run,
    input wire logic              period_match,
    input wire logic              time_base_event
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes are excluded from the step checks, since the counter is writable at any time.
    chk_rd_dir: assert property ($past(reg_rd) && $past(reg_addr) == `TB_OFF_COUNTER |->
        reg_rdata == {$past(count_down_flag), $past(count_value)}) else $error("counter read mismatch");
    chk_stop_hold: assert property (!$past(time_base_run) && !$past(reg_wr) |-> $stable(count_value))
        else $error("counter moved while stopped");
    chk_idle_quiet: assert property (!$past(time_base_run) |-> !period_match && !time_base_event)
        else $error("pulse while stopped");
    chk_match_wrap: assert property (period_match |-> count_value == '0 || count_down_flag)
        else $error("period match without wrap or reversal");
    chk_match_single: assert property (period_match |=> !period_match)
        else $error("period match longer than one cycle");
    chk_down_step: assert property (count_down_flag && $past(count_down_flag) && $changed(count_value)
        && !$past(reg_wr) |-> count_value == CNT_W'($past(count_value) - 1'b1)) else $error("bad down step");
    chk_up_step: assert property (!count_down_flag && !$past(count_down_flag) && $changed(count_value)
        && !$past(reg_wr) |-> count_value == CNT_W'($past(count_value) + 1'b1) || count_value == '0)
        else $error("bad up step");
    chk_turn_up: assert property ($fell(count_down_flag) && !$past(reg_wr) |-> count_value == 1)
        else $error("bad turnaround at zero");
    chk_event_place: assert property (time_base_event |-> count_value <= 1 || count_down_flag)
        else $error("event away from a turnaround");

    cover property (period_match);
    cover property (time_base_event);
    cover property ($fell(count_down_flag));
    cover property ($fell(time_base_run) && count_value == '0);
endmodule

// >>> testbench.sv
// Self-checking bench of the PWM time base over its register port and time base outputs.
// Assumes the map header is on the include path and the checker file is compiled before it.
`timescale 1ns/1ps
`include "pwm_time_base_map.svh"
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module testbench;
    logic        clk_sys;
    logic        reset;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [14:0] count_value;
    logic        count_down_flag;
    logic        time_base_run;
    logic        period_match;
    logic        time_base_event;
    logic [31:0] exp_q[$];
    logic [31:0] note;
    logic        rd_seen;
    logic [7:0]  rnd;
    logic [14:0] per;
    int          num_errors;
    int          n_compared;
    int          n_ev;
    int          gap;
    int          base;
    localparam logic [15:0] CFG [7] = '{16'h8000, 16'h8210, 16'h8102, 16'h8003, 16'h8103, 16'h8022, 16'h8033};

    pwm_time_base i_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_value(count_value),
        .count_down_flag(count_down_flag), .time_base_run(time_base_run), .period_match(period_match),
        .time_base_event(time_base_event));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe, so each note is taken off at that edge.
    always @(posedge clk_sys) begin
        if (rd_seen) begin
            note = exp_q.pop_front();
            `CHECK(reg_rdata & note[31:16], note[15:0])
        end
        rd_seen = reg_rd;
        if (time_base_event === 1'b1) n_ev <= n_ev + 1;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        exp_q.push_back({m, e});
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wait_ev(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (time_base_event !== 1'b1 && n < 3000);
        if (n >= 3000) `CHECK(1'b0, 1'b1)
    endtask

    task automatic give_verdict();
        $display("Comparisons: %0d, mismatches: %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        num_errors++;
        give_verdict();
    end

    initial begin
        {reset, reg_addr, reg_wdata, reg_wr, reg_rd, rd_seen} = {1'b1, 23'h0};
        {num_errors, n_compared, n_ev, rnd} = {96'h0, 8'h38};
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int a = 0; a < 4; a++) rd(a[3:0], 16'hFFFF, 16'h0000);
        rd(4'hF, 16'hFFFF, 16'h0000);
        $display("Test reset values done");
        // A zero period must freeze the counter and lock the period register while running.
        wr(`TB_OFF_CONTROL, 16'h8000);
        repeat (20) @(posedge clk_sys);
        `CHECK(n_ev, 0)
        `CHECK(count_value, 15'h0000)
        wr(`TB_OFF_PERIOD, 16'h0005);
        rd(`TB_OFF_PERIOD, 16'hFFFF, 16'h0000);
        rd(`TB_OFF_STATUS, 16'h0002, 16'h0002);
        wr(`TB_OFF_CONTROL, 16'h0000);
        rnd = lfsr(rnd);
        per = 15'd2 + rnd[2:0];
        wr(`TB_OFF_PERIOD, {1'b0, per});
        rd(`TB_OFF_PERIOD, 16'hFFFF, {1'b0, per});
        rnd = lfsr(rnd);
        wr(`TB_OFF_COUNTER, {8'h80, rnd});
        rd(`TB_OFF_COUNTER, 16'hFFFF, {8'h00, rnd});
        $display("Test period lock done");
        for (int i = 0; i < 7; i++) begin
            wr(`TB_OFF_CONTROL, 16'h0000);
            wr(`TB_OFF_COUNTER, 16'h0000);
            wr(`TB_OFF_CONTROL, CFG[i]);
            wait_ev(gap);
            wait_ev(gap);
            base = (CFG[i][1:0] == 2'b00) ? per + 1 : (CFG[i][1:0] == 2'b10) ? 2 * per : per;
            `CHECK(gap, base * (CFG[i][11:8] + 1) * (1 << (2 * CFG[i][5:4])))
            if (i == 2) begin
                while (period_match !== 1'b1) @(posedge clk_sys);
                `CHECK(count_down_flag, 1'b1)
                rd(`TB_OFF_COUNTER, 16'h8000, 16'h8000);
            end
        end
        $display("Test mode intervals done");
        // Single-shot ignores the postscaler and stops itself after one period.
        wr(`TB_OFF_CONTROL, 16'h0000);
        wr(`TB_OFF_COUNTER, 16'h0000);
        wr(`TB_OFF_STATUS, 16'h0001);
        base = n_ev;
        wr(`TB_OFF_CONTROL, 16'h8301);
        wait_ev(gap);
        `CHECK(time_base_run, 1'b0)
        `CHECK(count_value, 15'h0000)
        `CHECK(period_match, 1'b1)
        repeat (4 * per) @(posedge clk_sys);
        `CHECK(n_ev - base, 1)
        rd(`TB_OFF_CONTROL, 16'hFFFF, 16'h0301);
        rd(`TB_OFF_STATUS, 16'h0009, 16'h0001);
        $display("Test single shot done");
        repeat (2) @(posedge clk_sys);
        give_verdict();
    end
endmodule

bind pwm_time_base pwm_time_base_chk #(.CNT_W(CNT_W), .DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_chk (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_value(count_value), .count_down_flag(count_down_flag),
    .time_base_run(time_base_run), .period_match(period_match), .time_base_event(time_base_event));
